// ### logic/dma_seq_regs.svh
`ifndef DMA_SEQ_REGS_SVH
`define DMA_SEQ_REGS_SVH

`define REG_CTRL 6'h00
`define REG_STATUS 6'h04
`define REG_INT_STAT 6'h08
`define REG_INT_MASK 6'h0c
`define REG_CH_CFG 6'h10
`define REG_COUNT0 6'h14
`define CTRL_ROTATE 0
`define CTRL_EXT_WRITE 1
`define CTRL_ENABLE 2
`define CTRL_RESET 32'h0000_0000
`define COUNT_RESET 14'h0000
`define EV_FINAL 0
`define EV_CYCLE 1
`define EV_LOST 2
`define EV_BITS 3
`define ADDR_BITS 6

`endif

// ### logic/dma_seq_pkg.sv
package dma_seq_pkg;
	typedef enum {ST_IDLE, ST_REQ, ST_S1, ST_S2, ST_S3, ST_WAIT, ST_S4}
		seq_state_e;
	typedef enum logic [1:0] {MODE_VERIFY, MODE_WRITE, MODE_READ, MODE_NONE}
		xfer_mode_e;
	typedef struct packed {
		logic memory_read_strobe_n;
		logic memory_write_strobe_n;
		logic io_read_strobe_n;
		logic io_write_strobe_n;
	} strobes_s;
	typedef logic [3:0] chan_t;
endpackage

// ### logic/channel_arbiter.sv
`timescale 1ns/1ps
module channel_arbiter #(
	parameter int N = 4
) (
	input wire logic [N-1:0] req, // Sampled requests
	input wire logic rotate, // Rotating priority
	input wire logic [N-1:0] last_grant, // Last served channel
	output logic [N-1:0] grant, // One-hot winner
	output logic any // Any request
);
	logic [2*N-1:0] dbl;
	logic [2*N-1:0] pick;
	logic [N-1:0] start;
	always_comb begin
		start = rotate ? {last_grant[N-2:0], last_grant[N-1]} :
			{{(N-1){1'b0}}, 1'b1};
		if (start == '0)
			start = {{(N-1){1'b0}}, 1'b1};
		dbl = {req, req};
		// Lowest set bit at or above start, wrapping around
		pick = dbl & ~(dbl - {{N{1'b0}}, start});
		grant = pick[N-1:0] | pick[2*N-1:N];
		any = |req;
	end
endmodule

// ### logic/dma_cycle_sequencer.sv
// Added by the designer: the register addresses and the AXI4-Lite slave port.
`timescale 1ns/1ps
`include "dma_seq_regs.svh"
// Summary of operation
// - Seven states: idle, request, S1-S4, wait
// - Request seen in idle: raise hold, await grant
// - Resolve fixed or rotating priority in request
// - After grant, acknowledge only winning channel low
// - No ready at S3: wait until ready
// - Extended write or verify skip wait states
// - Grant lost: finish cycle, return idle
// - Peripheral-to-memory: io read S2, mem write S3
// - Memory-to-peripheral: mem read S2, io write S3
// - Verify: all four strobes stay inactive
// - Keep bus while request high and count not final
// - Low address on pins, high via latch
module dma_cycle_sequencer #(
	parameter int N = 4
) (
	input wire logic aclk, // Clock
	input wire logic aresetn, // Sync reset, low
	input wire logic [N-1:0] channel_request, // Peripheral requests
	input wire logic bus_hold_grant, // Host grant
	input wire logic ready, // Slow-device ready
	output logic bus_hold_request, // Hold request to host
	output logic [N-1:0] channel_acknowledge_n, // Acknowledges
	output dma_seq_pkg::strobes_s strobes, // Read/write strobes
	output logic final_count_flag, // Terminal count
	output logic [7:0] addr_low, // Low address bits
	output logic [7:0] data_out, // High address on data
	output logic data_oe, // Data pins driven
	output logic high_address_latch_strobe, // Latch high byte
	output logic irq, // Interrupt
	input wire logic [`ADDR_BITS-1:0] s_axi_awaddr, // AXI
	input wire logic s_axi_awvalid, // AXI
	output logic s_axi_awready, // AXI
	input wire logic [31:0] s_axi_wdata, // AXI
	input wire logic [3:0] s_axi_wstrb, // AXI
	input wire logic s_axi_wvalid, // AXI
	output logic s_axi_wready, // AXI
	output logic [1:0] s_axi_bresp, // AXI
	output logic s_axi_bvalid, // AXI
	input wire logic s_axi_bready, // AXI
	input wire logic [`ADDR_BITS-1:0] s_axi_araddr, // AXI
	input wire logic s_axi_arvalid, // AXI
	output logic s_axi_arready, // AXI
	output logic [31:0] s_axi_rdata, // AXI
	output logic [1:0] s_axi_rresp, // AXI
	output logic s_axi_rvalid, // AXI
	input wire logic s_axi_rready // AXI
);
	import dma_seq_pkg::*;

	seq_state_e state_reg;
	logic [N-1:0] req_m, req_s, hold_m, hold_s, rdy_m, rdy_s;
	logic [31:0] ctrl_reg;
	logic [2*N-1:0] mode_reg;
	logic [13:0] count_reg [N];
	logic [15:0] addr_reg [N];
	logic [`EV_BITS-1:0] int_stat_reg, int_mask_reg, ev;
	logic [N-1:0] win_reg, grant, last_reg;
	logic any;
	logic [1:0] ch;
	xfer_mode_e mode;
	logic tc_now, lost_reg;
	logic [`ADDR_BITS-1:0] wr_addr;
	logic [31:0] wd_reg;
	// Both beats held and no response pending
	wire wr_go = !s_axi_awready && !s_axi_wready && !s_axi_bvalid;
	wire [1:0] wr_idx = 2'((wr_addr - `REG_COUNT0) >> 2);

	// Pins from outside pass two flops
	always_ff @(posedge aclk) begin
		req_m <= {{(N-1){1'b0}}, 1'b0} | channel_request;
		req_s <= req_m;
		hold_m <= {N{bus_hold_grant}};
		hold_s <= hold_m;
		rdy_m <= {N{ready}};
		rdy_s <= rdy_m;
	end
	wire grant_s = hold_s[0];
	wire ready_s = rdy_s[0];

	channel_arbiter #(.N(N)) u_arb (
		.req(req_s & ~{N{~ctrl_reg[`CTRL_ENABLE]}}),
		.rotate(ctrl_reg[`CTRL_ROTATE]),
		.last_grant(last_reg),
		.grant(grant),
		.any(any)
	);

	always_comb begin
		ch = 2'd0;
		for (int i = 0; i < N; i++)
			if (win_reg[i])
				ch = 2'(i);
		mode = xfer_mode_e'(mode_reg[2*ch +: 2]);
		tc_now = (count_reg[ch] == `COUNT_RESET);
	end

	// Cycle sequencer
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			state_reg <= ST_IDLE;
			win_reg <= '0;
			last_reg <= '0;
			lost_reg <= 1'b0;
		end else begin
			lost_reg <= 1'b0;
			case (state_reg)
			ST_IDLE: begin
				if (any)
					state_reg <= ST_REQ;
			end
			ST_REQ: begin
				win_reg <= grant;
				if (!any)
					state_reg <= ST_IDLE;
				else if (grant_s)
					state_reg <= ST_S1;
			end
			ST_S1: state_reg <= ST_S2;
			ST_S2: state_reg <= ST_S3;
			ST_S3: begin
				// Ext write / verify skip waits
				if (ready_s || mode == MODE_VERIFY ||
					ctrl_reg[`CTRL_EXT_WRITE])
					state_reg <= ST_S4;
				else
					state_reg <= ST_WAIT;
			end
			ST_WAIT: begin
				if (ready_s)
					state_reg <= ST_S4;
			end
			ST_S4: begin
				last_reg <= win_reg;
				// Cycle always completes first
				if (!grant_s) begin
					state_reg <= ST_IDLE;
					lost_reg <= 1'b1;
				end else if (any && !tc_now)
					state_reg <= ST_REQ;
				else
					state_reg <= ST_IDLE;
			end
			default: state_reg <= ST_IDLE;
			endcase
		end
	end

	wire in_cycle = state_reg inside {ST_S1, ST_S2, ST_S3, ST_WAIT, ST_S4};

	// Outputs registered
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			bus_hold_request <= 1'b0;
			channel_acknowledge_n <= '1;
			strobes <= '1;
			high_address_latch_strobe <= 1'b0;
			data_oe <= 1'b0;
			addr_low <= 8'h00;
			data_out <= 8'h00;
		end else begin
			bus_hold_request <= (state_reg != ST_IDLE) ||
				any;
			channel_acknowledge_n <= ~(in_cycle ? win_reg : '0);
			strobes.io_read_strobe_n <= !(mode == MODE_WRITE &&
				state_reg inside {ST_S1, ST_S2, ST_S3, ST_WAIT});
			strobes.memory_write_strobe_n <= !(mode == MODE_WRITE &&
				state_reg inside {ST_S2, ST_S3, ST_WAIT});
			strobes.memory_read_strobe_n <= !(mode == MODE_READ &&
				state_reg inside {ST_S1, ST_S2, ST_S3, ST_WAIT});
			strobes.io_write_strobe_n <= !(mode == MODE_READ &&
				state_reg inside {ST_S2, ST_S3, ST_WAIT});
			high_address_latch_strobe <= (state_reg == ST_REQ &&
				grant_s && any);
			data_oe <= (state_reg == ST_REQ && grant_s && any);
			addr_low <= addr_reg[ch][7:0];
			data_out <= addr_reg[ch][15:8];
		end
	end

	// Count, address and final count
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			final_count_flag <= 1'b0;
			for (int i = 0; i < N; i++) begin
				count_reg[i] <= `COUNT_RESET;
				addr_reg[i] <= 16'h0000;
			end
		end else begin
			final_count_flag <= (state_reg == ST_S3 || state_reg == ST_WAIT)
				&& tc_now;
			if (state_reg == ST_S4) begin
				addr_reg[ch] <= addr_reg[ch] + 16'h0001;
				if (!tc_now)
					count_reg[ch] <= count_reg[ch] - 14'h0001;
			end
			if (wr_go && wr_addr >= `REG_COUNT0 &&
				wr_addr < 6'(`REG_COUNT0 + 4*N)) begin
				count_reg[wr_idx] <= wd_reg[13:0];
				addr_reg[wr_idx] <= wd_reg[31:16];
			end
		end
	end

	// Interrupts: sticky, set wins over clear
	assign ev = {lost_reg, state_reg == ST_S4,
		final_count_flag && state_reg == ST_S4};
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			int_stat_reg <= '0;
			irq <= 1'b0;
		end else begin
			int_stat_reg <= (int_stat_reg & ~((wr_go &&
				wr_addr == `REG_INT_STAT) ?
				wd_reg[`EV_BITS-1:0] : '0)) | ev;
			irq <= |(int_stat_reg & int_mask_reg);
		end
	end

	// AXI4-Lite slave; ready low marks a beat held
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			s_axi_awready <= 1'b1;
			s_axi_wready <= 1'b1;
			wr_addr <= '0;
			wd_reg <= 32'h0000_0000;
			s_axi_bvalid <= 1'b0;
			s_axi_bresp <= 2'b00;
			ctrl_reg <= `CTRL_RESET;
			mode_reg <= '0;
			int_mask_reg <= '0;
		end else begin
			if (s_axi_awvalid && s_axi_awready) begin
				s_axi_awready <= 1'b0;
				wr_addr <= s_axi_awaddr;
			end
			// Data latched: master may drop it once taken
			if (s_axi_wvalid && s_axi_wready) begin
				s_axi_wready <= 1'b0;
				wd_reg <= s_axi_wdata;
			end
			if (wr_go) begin
				s_axi_awready <= 1'b1;
				s_axi_wready <= 1'b1;
				s_axi_bvalid <= 1'b1;
				s_axi_bresp <= 2'b00;
				case (wr_addr)
				`REG_CTRL: ctrl_reg <= wd_reg;
				`REG_CH_CFG: mode_reg <= wd_reg[2*N-1:0];
				`REG_INT_MASK: int_mask_reg <= wd_reg[`EV_BITS-1:0];
				`REG_STATUS, `REG_INT_STAT: ;
				default: if (wr_addr < `REG_COUNT0 ||
					wr_addr >= 6'(`REG_COUNT0 + 4*N))
					s_axi_bresp <= 2'b10;
				endcase
			end else if (s_axi_bready)
				s_axi_bvalid <= 1'b0;
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			s_axi_arready <= 1'b1;
			s_axi_rvalid <= 1'b0;
			s_axi_rdata <= 32'h0000_0000;
			s_axi_rresp <= 2'b00;
		end else if (s_axi_arvalid && s_axi_arready) begin
			s_axi_arready <= 1'b0;
			s_axi_rvalid <= 1'b1;
			s_axi_rresp <= 2'b00;
			case (s_axi_araddr)
			`REG_CTRL: s_axi_rdata <= ctrl_reg;
			`REG_STATUS: s_axi_rdata <= {20'h00000, win_reg,
				5'(state_reg), final_count_flag, bus_hold_request,
				grant_s};
			`REG_INT_STAT: s_axi_rdata <= 32'(int_stat_reg);
			`REG_INT_MASK: s_axi_rdata <= 32'(int_mask_reg);
			`REG_CH_CFG: s_axi_rdata <= 32'(mode_reg);
			default: begin
				s_axi_rdata <= 32'h0000_0000;
				s_axi_rresp <= 2'b10;
			end
			endcase
		end else if (s_axi_rvalid && s_axi_rready) begin
			s_axi_rvalid <= 1'b0;
			s_axi_arready <= 1'b1;
		end
	end

	wait_after_s3_a: assert property (@(posedge aclk) disable iff (!aresetn)
		state_reg == ST_S3 && !ready_s && mode != MODE_VERIFY &&
		!ctrl_reg[`CTRL_EXT_WRITE] |=> state_reg == ST_WAIT)
		else $error("no wait state");
	verify_quiet_a: assert property (@(posedge aclk) disable iff (!aresetn)
		mode == MODE_VERIFY && $stable(mode) && in_cycle |=> strobes == '1)
		else $error("strobe in verify");
	ack_one_a: assert property (@(posedge aclk) disable iff (!aresetn)
		$onehot0(~channel_acknowledge_n))
		else $error("multiple acks");
	lost_idle_a: assert property (@(posedge aclk) disable iff (!aresetn)
		state_reg == ST_S4 && !grant_s |=> state_reg == ST_IDLE)
		else $error("grant loss ignored");
	hold_wait_a: assert property (@(posedge aclk) disable iff (!aresetn)
		state_reg == ST_REQ && any && !grant_s |=> state_reg == ST_REQ)
		else $error("left request without grant");
	io_read_s2_a: assert property (@(posedge aclk) disable iff (!aresetn)
		state_reg == ST_S1 && mode == MODE_WRITE |=>
		!strobes.io_read_strobe_n)
		else $error("io read late");
	mem_read_s2_a: assert property (@(posedge aclk) disable iff (!aresetn)
		state_reg == ST_S1 && mode == MODE_READ |=>
		!strobes.memory_read_strobe_n)
		else $error("memory read late");
	cycle_cov: cover property (@(posedge aclk) state_reg == ST_WAIT);
	done_cov: cover property (@(posedge aclk) final_count_flag);
	lost_cov: cover property (@(posedge aclk) lost_reg);
endmodule

// ### sim/host_partner.sv
`timescale 1ns/1ps
module host_partner (
	input wire logic aclk, // Clock
	input wire logic bus_hold_request, // Hold request
	input wire logic [3:0] channel_acknowledge_n, // Acks
	input wire logic high_address_latch_strobe, // Latch enable
	input wire logic [7:0] data_out, // High address byte
	input wire logic [3:0] want, // Requests to raise
	input wire logic kick, // Raise want
	input wire logic deny, // Host refuses bus
	input wire logic [3:0] lag, // Ready delay
	output logic [3:0] channel_request = 4'h0, // Requests
	output logic bus_hold_grant = 1'b0, // Grant
	output logic ready = 1'b0, // Memory ready
	output logic [7:0] high_byte = 8'h00 // Latched address
);
	logic [3:0] busy = 4'h0;
	always @(posedge aclk) begin
		// Drop a request only once it is acknowledged
		if (kick) channel_request <= want;
		else channel_request <= channel_request & channel_acknowledge_n;
		bus_hold_grant <= bus_hold_request & !deny;
		// Slow device: ready only after lag cycles of selection
		busy <= &channel_acknowledge_n ? 4'h0 : busy + 4'h1;
		ready <= !(&channel_acknowledge_n) && busy >= lag;
		if (high_address_latch_strobe) high_byte <= data_out;
	end
endmodule

// ### sim/tb_dma_cycle_sequencer.sv
`timescale 1ns/1ps
module tb_dma_cycle_sequencer;
	import dma_seq_pkg::*;
	logic aclk = 0, aresetn = 0, bus_hold_grant, ready, kick = 0, deny = 0;
	logic clr = 0, irq, bus_hold_request, final_count_flag, data_oe;
	logic high_address_latch_strobe, tc_seen, hold_seen, multi;
	logic [3:0] channel_request, channel_acknowledge_n, want = 0, lag = 0;
	logic [3:0] stb_seen, ack_seen, first, s_axi_wstrb = 4'hf;
	logic [7:0] addr_low, data_out, high_byte;
	strobes_s strobes;
	logic [5:0] s_axi_awaddr = 0, s_axi_araddr = 0;
	logic s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 0;
	logic s_axi_arvalid = 0, s_axi_rready = 0, s_axi_awready, s_axi_wready;
	logic s_axi_bvalid, s_axi_arready, s_axi_rvalid;
	logic [31:0] s_axi_wdata = 0, s_axi_rdata, d;
	logic [1:0] s_axi_bresp, s_axi_rresp, r;
	logic [7:0] mode_val [3] = '{8'h55, 8'haa, 8'h00};
	logic [3:0] stb_exp [3] = '{4'h6, 4'h9, 4'h0};
	int compares = 0, miscompares = 0, len, l0, i;
	wire idle = channel_request == 4'h0 && &channel_acknowledge_n &&
		!bus_hold_request;
	dma_cycle_sequencer u_dma_cycle_sequencer (.*);
	host_partner u_host_partner (.*);
	always #2.5 aclk = ~aclk;
	always @(posedge aclk) if (clr) begin
		{stb_seen, ack_seen, first, tc_seen, hold_seen, multi} <= 0;
		len <= 0;
	end else begin
		stb_seen <= stb_seen | ~strobes;
		ack_seen <= ack_seen | ~channel_acknowledge_n;
		if (first == 4'h0) first <= ~channel_acknowledge_n;
		tc_seen <= tc_seen | final_count_flag;
		hold_seen <= hold_seen | bus_hold_request;
		multi <= multi | ($countones(~channel_acknowledge_n) > 1);
		len <= len + (&channel_acknowledge_n ? 0 : 1);
	end
	task complete_run;
		$display("compares %0d miscompares %0d", compares, miscompares);
		if (miscompares == 0 && compares > 0) $display("All tests passed");
		else $display("Some tests failed");
		$finish;
	endtask
	task chk(input string n, input logic [31:0] s, input logic [31:0] e);
		compares++;
		if (s !== e) begin
			miscompares++;
			$display("BAD %s expected %h seen %h", n, e, s);
		end
	endtask
	task settle(input logic bad);
		if (bad) begin
			miscompares++;
			complete_run();
		end
		@(posedge aclk);
	endtask
	task automatic wr(input logic [5:0] a, input logic [31:0] v);
		int n;
		logic b;
		b = 0;
		s_axi_awaddr <= a;
		s_axi_wdata <= v;
		{s_axi_awvalid, s_axi_wvalid, s_axi_bready} <= 3'h7;
		for (n = 0; n < 50 && !b; n++) begin
			@(posedge aclk);
			if (s_axi_awready) s_axi_awvalid <= 0;
			if (s_axi_wready) s_axi_wvalid <= 0;
			b = s_axi_bvalid;
		end
		s_axi_bready <= 0;
		r = s_axi_bresp;
		settle(!b);
	endtask
	task automatic rd(input logic [5:0] a);
		int n;
		logic b;
		b = 0;
		s_axi_araddr <= a;
		{s_axi_arvalid, s_axi_rready} <= 2'h3;
		for (n = 0; n < 50 && !b; n++) begin
			@(posedge aclk);
			if (s_axi_arready) s_axi_arvalid <= 0;
			b = s_axi_rvalid;
			d = s_axi_rdata;
		end
		s_axi_rready <= 0;
		r = s_axi_rresp;
		settle(!b);
	endtask
	task start(input logic [3:0] w, input logic [3:0] l);
		clr <= 1;
		want <= w;
		kick <= |w;
		lag <= l;
		@(posedge aclk);
		clr <= 0;
		kick <= 0;
	endtask
	task automatic drain;
		int n;
		for (n = 0; n < 400 && !(n > 8 && idle); n++) @(posedge aclk);
		settle(n == 400);
	endtask
	initial begin
		repeat (16) @(posedge aclk);
		aresetn <= 1;
		@(posedge aclk);
		chk("hold", bus_hold_request, 0);
		chk("acks", channel_acknowledge_n, 4'hf);
		chk("strobes", strobes, 4'hf);
		rd(6'h00);
		chk("ctrl", d, 0);
		rd(6'h3c);
		chk("unmapped", r, 2'h2);
		$display("reset test done");
		for (i = 0; i < 4; i++) wr(6'h14 + 6'(4 * i), 32'h5a00_3fff);
		wr(6'h00, 32'h4);
		for (i = 0; i < 3; i++) begin
			wr(6'h10, {24'h0, mode_val[i]});
			start(4'h1, 4'h0);
			drain();
			chk("strobes seen", stb_seen, stb_exp[i]);
			chk("ack seen", ack_seen, 4'h1);
			chk("hold seen", hold_seen, 1);
			chk("count flag", tc_seen, 0);
		end
		chk("high byte", high_byte, 8'h5a);
		$display("mode test done");
		start(4'h3, 4'h0);
		drain();
		chk("fixed winner", first, 4'h1);
		chk("one ack", multi, 0);
		wr(6'h00, 32'h5);
		start(4'h1, 4'h0);
		drain();
		start(4'h3, 4'h0);
		drain();
		chk("rotating winner", first, 4'h2);
		wr(6'h00, 32'h4);
		$display("priority test done");
		// Write mode on all channels: verify would skip waits
		wr(6'h10, 32'h55);
		start(4'h1, 4'h0);
		drain();
		l0 = len;
		start(4'h1, 4'h6);
		drain();
		chk("wait states", len > l0 + 3, 1);
		deny <= 1;
		start(4'h1, 4'h0);
		repeat (40) @(posedge aclk);
		chk("ungranted", ack_seen, 0);
		chk("hold kept", bus_hold_request, 1);
		deny <= 0;
		drain();
		chk("granted", ack_seen, 4'h1);
		$display("bus test done");
		wr(6'h14, 32'h5a00_0000);
		wr(6'h0c, 32'h7);
		wr(6'h08, 32'h7);
		start(4'h1, 4'h0);
		drain();
		chk("count flag", tc_seen, 1);
		rd(6'h08);
		chk("final event", d[0], 1);
		chk("irq", irq, 1);
		wr(6'h0c, 32'h0);
		chk("irq masked", irq, 0);
		wr(6'h0c, 32'h7);
		wr(6'h08, 32'h7);
		chk("irq cleared", irq, 0);
		rd(6'h08);
		chk("status cleared", d, 0);
		$display("count test done");
		complete_run();
	end
endmodule
